// ### hdl/opamp_cmp_defs.svh
// Register offsets, field positions and reset values
`ifndef OPAMP_CMP_DEFS_SVH
`define OPAMP_CMP_DEFS_SVH
`define AMP1_CTRL_OFS 4'h0
`define AMP2_CTRL_OFS 4'h1
`define AMP3_CTRL_OFS 4'h2
`define MISC_CTRL_OFS 4'h3
`define CMP_CTRL_OFS 4'h4
`define PORTB_DATA_OFS 4'h5
`define PORTB_DIR_OFS 4'h6
`define PORTB_PULL_OFS 4'h7
`define IRQ_STAT_OFS 4'h8
`define IRQ_MASK_OFS 4'h9
`define LIVE_STAT_OFS 4'hA
`define CTL_EN_BIT 0
`define CTL_REF_BIT 1
`define CTL_OFM_BIT 2
`define CTL_TRIM_LSB 3
`define CTL_TRIM_MSB 6
`define MISC_GAIN_LSB 0
`define MISC_GAIN_MSB 2
`define MISC_COMPARATOR_OUTPUT_ENABLE_BIT 3
`define CTL_RST 8'h00
`define MISC_RST 8'h00
`define PORTB_DATA_RST 3'h0
`define PORTB_DIR_RST 3'h7
`define PORTB_PULL_RST 3'h0
`define IRQ_RST 4'h0
`define IRQ_CMP_BIT 0
`define IRQ_AMP_LSB 1
`define IRQ_AMP_MSB 3
`endif

// ### hdl/opamp_cmp_pkg.sv
// Shared types of the amplifier and comparator control block
package opamp_cmp_pkg;
  typedef logic [3:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] trim_t;
  typedef logic [2:0] gain_t;
endpackage : opamp_cmp_pkg

// ### hdl/amp_ctl_if.sv
// Control bits in, analog switch settings out, for one amplifier or the comparator
`timescale 1ns/1ps
interface amp_ctl_if;
  logic enable;
  logic ref_sel;
  logic offset_mode;
  opamp_cmp_pkg::trim_t trim;
  logic en_out;
  logic sw_first;
  logic sw_second;
  logic sw_short;
  opamp_cmp_pkg::trim_t trim_out;
  modport src (output enable, ref_sel, offset_mode, trim,
    input en_out, sw_first, sw_second, sw_short, trim_out);
  modport dec (input enable, ref_sel, offset_mode, trim,
    output en_out, sw_first, sw_second, sw_short, trim_out);
endinterface : amp_ctl_if

// ### hdl/amp_switch_decode.sv
// Registered switch decode for one amplifier or the comparator
`timescale 1ns/1ps
module amp_switch_decode (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control bits and switch settings
  amp_ctl_if.dec ctl
);
  wire close_first;
  wire close_second;

  // Normal mode closes both inputs; offset mode keeps only the reference side
  assign close_first = ~ctl.offset_mode | ctl.ref_sel;
  assign close_second = ~ctl.offset_mode | ~ctl.ref_sel;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl.en_out <= 1'b0;
      ctl.sw_first <= 1'b1;
      ctl.sw_second <= 1'b1;
      ctl.sw_short <= 1'b0;
      ctl.trim_out <= 4'h0;
    end else begin
      ctl.en_out <= ctl.enable;
      ctl.sw_first <= close_first;
      ctl.sw_second <= close_second;
      ctl.sw_short <= ctl.offset_mode;
      ctl.trim_out <= ctl.trim;
    end
  end

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_SHORT_CLOSED: assert property (ctl.offset_mode |=> ctl.sw_short)
    else $error("feedback short not closed in offset mode");
  AST_REF_LOW: assert property (ctl.offset_mode && !ctl.ref_sel
      |=> !ctl.sw_first && ctl.sw_second)
    else $error("reference select 0 switch pattern wrong");
  AST_REF_HIGH: assert property (ctl.offset_mode && ctl.ref_sel
      |=> ctl.sw_first && !ctl.sw_second)
    else $error("reference select 1 switch pattern wrong");
  AST_NORMAL_MODE: assert property (!ctl.offset_mode
      |=> ctl.sw_first && ctl.sw_second && !ctl.sw_short)
    else $error("normal mode switch pattern wrong");
  AST_ENABLE_FOLLOWS: assert property (##1 ctl.en_out == $past(ctl.enable))
    else $error("enable output does not follow its bit");
endmodule : amp_switch_decode

// ### hdl/opamp_cmp_ctrl.sv
// Amplifier, bias, comparator and shared port pin control with register port
`timescale 1ns/1ps
`include "opamp_cmp_defs.svh"
module opamp_cmp_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire opamp_cmp_pkg::addr_t reg_addr,
  input wire opamp_cmp_pkg::byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output opamp_cmp_pkg::byte_t reg_rdata,
  // Configuration option
  input wire logic bias_internal_opt,
  // Analog amplifiers
  input wire logic [2:0] amp_out_status,
  output logic [2:0] amp_enable,
  output logic [2:0] amp_sw_first,
  output logic [2:0] amp_sw_second,
  output logic [2:0] amp_sw_short,
  output logic [11:0] amp_trim,
  output opamp_cmp_pkg::gain_t amp2_gain,
  output logic bias_sw_close,
  // Analog comparator
  input wire logic comp_out,
  output logic cmp_enable,
  output logic cmp_sw_first,
  output logic cmp_sw_second,
  output logic cmp_sw_short,
  output opamp_cmp_pkg::trim_t cmp_trim,
  // Shared port B lines
  input wire logic [2:0] port_b_in,
  output logic [2:0] port_b_out,
  output logic [2:0] port_b_oe,
  output logic [2:0] port_b_pullup,
  // Interrupt
  output logic irq
);
  // Index 0..2 amplifiers, index 3 comparator
  opamp_cmp_pkg::byte_t ctl_ff [0:3];
  opamp_cmp_pkg::byte_t misc_ff;
  logic [2:0] pb_data_ff;
  logic [2:0] pb_dir_ff;
  logic [2:0] pb_pull_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] nxt_irq_stat;
  logic irq_ff;
  logic bias_int_ff;
  logic captured_ff;
  logic bias_sw_ff;
  logic comp_prev_ff;
  logic [2:0] amp_prev_ff;
  opamp_cmp_pkg::gain_t gain_ff;
  logic [2:0] pb_out_ff;
  logic [2:0] pb_oe_ff;
  logic [2:0] pb_pull_out_ff;
  opamp_cmp_pkg::byte_t rdata_ff;
  opamp_cmp_pkg::byte_t rd_mux;

  wire wr_misc;
  wire wr_pb_data;
  wire wr_pb_dir;
  wire wr_pb_pull;
  wire wr_mask;
  wire rd_stat;
  wire [3:0] wr_ctl;
  wire cmp_en;
  wire cout_en;
  wire cout_drive;
  wire pb01_off;
  wire any_amp_en;
  wire cmp_event;
  wire [2:0] amp_event;
  wire [3:0] events;
  wire [2:0] pb_read;

  assign wr_ctl[0] = reg_wr && (reg_addr == `AMP1_CTRL_OFS);
  assign wr_ctl[1] = reg_wr && (reg_addr == `AMP2_CTRL_OFS);
  assign wr_ctl[2] = reg_wr && (reg_addr == `AMP3_CTRL_OFS);
  assign wr_ctl[3] = reg_wr && (reg_addr == `CMP_CTRL_OFS);
  assign wr_misc = reg_wr && (reg_addr == `MISC_CTRL_OFS);
  assign wr_pb_data = reg_wr && (reg_addr == `PORTB_DATA_OFS);
  assign wr_pb_dir = reg_wr && (reg_addr == `PORTB_DIR_OFS);
  assign wr_pb_pull = reg_wr && (reg_addr == `PORTB_PULL_OFS);
  assign wr_mask = reg_wr && (reg_addr == `IRQ_MASK_OFS);
  assign rd_stat = reg_rd && (reg_addr == `IRQ_STAT_OFS);

  assign cmp_en = ctl_ff[3][`CTL_EN_BIT];
  assign cout_en = misc_ff[`MISC_COMPARATOR_OUTPUT_ENABLE_BIT];
  assign cout_drive = cmp_en && cout_en;
  // Output enable alone already frees the two input pins
  assign pb01_off = cmp_en || cout_en;
  assign any_amp_en = ctl_ff[0][`CTL_EN_BIT] || ctl_ff[1][`CTL_EN_BIT]
    || ctl_ff[2][`CTL_EN_BIT];

  // Edge detect only while enabled, so a disabled comparator raises nothing
  assign cmp_event = cmp_en && (comp_out != comp_prev_ff);
  // Output flips show when a trim step crossed the offset
  assign amp_event = amp_out_status ^ amp_prev_ff;
  assign events = {amp_event, cmp_event};
  // Set beats the read that clears
  assign nxt_irq_stat = (rd_stat ? 4'h0 : irq_stat_ff) | events;

  // Reading the third line returns the comparator state when it drives it
  assign pb_read[1:0] = pb01_off ? 2'b00 : port_b_in[1:0];
  assign pb_read[2] = cout_drive ? comp_prev_ff : port_b_in[2];

  always_comb begin
    if (reg_addr == `AMP1_CTRL_OFS) begin
      rd_mux = ctl_ff[0];
    end else if (reg_addr == `AMP2_CTRL_OFS) begin
      rd_mux = ctl_ff[1];
    end else if (reg_addr == `AMP3_CTRL_OFS) begin
      rd_mux = ctl_ff[2];
    end else if (reg_addr == `MISC_CTRL_OFS) begin
      rd_mux = misc_ff;
    end else if (reg_addr == `CMP_CTRL_OFS) begin
      rd_mux = ctl_ff[3];
    end else if (reg_addr == `PORTB_DATA_OFS) begin
      rd_mux = {5'h00, pb_read};
    end else if (reg_addr == `PORTB_DIR_OFS) begin
      rd_mux = {5'h00, pb_dir_ff};
    end else if (reg_addr == `PORTB_PULL_OFS) begin
      rd_mux = {5'h00, pb_pull_ff};
    end else if (reg_addr == `IRQ_STAT_OFS) begin
      rd_mux = {4'h0, irq_stat_ff};
    end else if (reg_addr == `IRQ_MASK_OFS) begin
      rd_mux = {4'h0, irq_mask_ff};
    end else if (reg_addr == `LIVE_STAT_OFS) begin
      rd_mux = {2'h0, amp_prev_ff, comp_prev_ff, bias_sw_ff, bias_int_ff};
    end else begin
      rd_mux = 8'h00;
    end
  end

  // One copy of the switch decode per amplifier plus the comparator
  amp_ctl_if ctl [4] ();
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          ctl_ff[gi] <= `CTL_RST;
        end else if (wr_ctl[gi]) begin
          ctl_ff[gi] <= reg_wdata;
        end
      end
      assign ctl[gi].enable = ctl_ff[gi][`CTL_EN_BIT];
      assign ctl[gi].ref_sel = ctl_ff[gi][`CTL_REF_BIT];
      assign ctl[gi].offset_mode = ctl_ff[gi][`CTL_OFM_BIT];
      assign ctl[gi].trim = ctl_ff[gi][`CTL_TRIM_MSB:`CTL_TRIM_LSB];
      amp_switch_decode amp_switch_decode_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ctl(ctl[gi].dec)
      );
      // Trim field reaches its cell untouched, one cycle on
      AST_TRIM_PASS: assert property (@(posedge sys_clk) disable iff (!resetn)
          ##1 ctl[gi].trim_out == $past(ctl_ff[gi][`CTL_TRIM_MSB:`CTL_TRIM_LSB]))
        else $error("trim field not passed to its cell");
      if (gi < 3) begin : g_amp
        assign amp_enable[gi] = ctl[gi].en_out;
        assign amp_sw_first[gi] = ctl[gi].sw_first;
        assign amp_sw_second[gi] = ctl[gi].sw_second;
        assign amp_sw_short[gi] = ctl[gi].sw_short;
        assign amp_trim[gi*4 +: 4] = ctl[gi].trim_out;
      end
    end
  endgenerate

  assign cmp_enable = ctl[3].en_out;
  assign cmp_sw_first = ctl[3].sw_first;
  assign cmp_sw_second = ctl[3].sw_second;
  assign cmp_sw_short = ctl[3].sw_short;
  assign cmp_trim = ctl[3].trim_out;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      misc_ff <= `MISC_RST;
      pb_data_ff <= `PORTB_DATA_RST;
      pb_dir_ff <= `PORTB_DIR_RST;
      pb_pull_ff <= `PORTB_PULL_RST;
      irq_mask_ff <= `IRQ_RST;
    end else begin
      if (wr_misc) misc_ff <= reg_wdata;
      if (wr_pb_data) pb_data_ff <= reg_wdata[2:0];
      if (wr_pb_dir) pb_dir_ff <= reg_wdata[2:0];
      if (wr_pb_pull) pb_pull_ff <= reg_wdata[2:0];
      if (wr_mask) irq_mask_ff <= reg_wdata[3:0];
    end
  end

  // Option is a strap: take it once after release, never follow it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      captured_ff <= 1'b0;
      bias_int_ff <= 1'b0;
    end else if (!captured_ff) begin
      captured_ff <= 1'b1;
      bias_int_ff <= bias_internal_opt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bias_sw_ff <= 1'b0;
      gain_ff <= 3'h0;
      comp_prev_ff <= 1'b0;
      amp_prev_ff <= 3'h0;
      irq_stat_ff <= `IRQ_RST;
      irq_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      bias_sw_ff <= bias_int_ff && any_amp_en;
      gain_ff <= misc_ff[`MISC_GAIN_MSB:`MISC_GAIN_LSB];
      comp_prev_ff <= comp_out;
      amp_prev_ff <= amp_out_status;
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Pin drive; lines 0-1 lose port driver and pull-ups under comparator use, line 2 only when the output is enabled
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pb_out_ff <= 3'h0;
      pb_oe_ff <= 3'h0;
      pb_pull_out_ff <= 3'h0;
    end else begin
      pb_out_ff[1:0] <= pb01_off ? 2'b00 : pb_data_ff[1:0];
      pb_oe_ff[1:0] <= pb01_off ? 2'b00 : ~pb_dir_ff[1:0];
      pb_pull_out_ff[1:0] <= pb01_off ? 2'b00 : pb_pull_ff[1:0];
      pb_out_ff[2] <= cout_en ? comp_out : pb_data_ff[2];
      pb_oe_ff[2] <= cout_en ? cmp_en : ~pb_dir_ff[2];
      pb_pull_out_ff[2] <= cout_en ? 1'b0 : pb_pull_ff[2];
    end
  end

  assign amp2_gain = gain_ff;
  assign bias_sw_close = bias_sw_ff;
  assign port_b_out = pb_out_ff;
  assign port_b_oe = pb_oe_ff;
  assign port_b_pullup = pb_pull_out_ff;
  assign irq = irq_ff;
  assign reg_rdata = rdata_ff;

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_cmp_flip;
    cmp_en && (comp_out != comp_prev_ff);
  endsequence
  sequence s_stat_read_quiet;
    rd_stat && !cmp_event;
  endsequence
  sequence s_bias_on;
    bias_int_ff && any_amp_en;
  endsequence
  sequence s_out_read;
    reg_rd && (reg_addr == `PORTB_DATA_OFS) && cout_drive;
  endsequence
  sequence s_in_read;
    reg_rd && (reg_addr == `PORTB_DATA_OFS) && pb01_off;
  endsequence

  AST_BIAS_CLOSE: assert property (s_bias_on |=> bias_sw_close)
    else $error("bias switches not closed");
  AST_BIAS_OPEN: assert property (!(bias_int_ff && any_amp_en)
      |=> !bias_sw_close)
    else $error("bias switches not opened");
  AST_AMP2_GAIN: assert property (##1 amp2_gain
      == $past(misc_ff[`MISC_GAIN_MSB:`MISC_GAIN_LSB]))
    else $error("second amplifier gain not from misc register");
  AST_GPIO_ALL: assert property (!cmp_en && !cout_en
      |=> port_b_oe == ~$past(pb_dir_ff))
    else $error("port lines not general I/O with comparator off");
  AST_GPIO_LEVELS: assert property (!cmp_en && !cout_en
      |=> port_b_out == $past(pb_data_ff) && port_b_pullup == $past(pb_pull_ff))
    else $error("plain I/O data or pull-up not passed to the pins");
  AST_INPUTS_ONLY: assert property (cmp_en && !cout_en
      |=> port_b_oe[1:0] == 2'b00 && port_b_oe[2] == !$past(pb_dir_ff[2]))
    else $error("comparator input pin setup wrong");
  AST_IN_READ: assert property (s_in_read
      |=> reg_rdata[1:0] == 2'b00)
    else $error("comparator input lines read as port data");
  AST_PB2_DRIVES: assert property (cout_drive
      |=> port_b_oe[2] && port_b_out[2] == $past(comp_out))
    else $error("third line not driving comparator output");
  AST_OUT_READ: assert property (s_out_read
      |=> reg_rdata[2] == $past(comp_prev_ff))
    else $error("third line read does not return comparator state");
  AST_PINS_OFF: assert property (cout_en
      |=> port_b_oe[1:0] == 2'b00 && port_b_pullup == 3'h0)
    else $error("port function or pull-up left on");

  // Other status bits may also hold the line high, so only demand it when masked in
  AST_CMP_FLAG: assert property (s_cmp_flip
      |=> irq_stat_ff[`IRQ_CMP_BIT] ##1 (irq || !$past(irq_mask_ff[`IRQ_CMP_BIT])))
    else $error("comparator change not flagged");
  AST_READ_CLEARS: assert property (s_stat_read_quiet
      |=> !irq_stat_ff[`IRQ_CMP_BIT])
    else $error("status read did not clear flag");
  // Output flips of the amplifiers are latched as calibration hints
  AST_AMP_FLAG: assert property (amp_event != 3'h0
      |=> (irq_stat_ff[`IRQ_AMP_MSB:`IRQ_AMP_LSB] & $past(amp_event)) == $past(amp_event))
    else $error("amplifier output change not latched");
  // Level interrupt runs one cycle behind the masked status
  AST_IRQ_ON: assert property ((irq_stat_ff & irq_mask_ff) != 4'h0
      |=> irq)
    else $error("interrupt low with an unmasked event");
  AST_IRQ_OFF: assert property ((irq_stat_ff & irq_mask_ff) == 4'h0
      |=> !irq)
    else $error("interrupt high with no unmasked event");

  // Read data last one cycle; the port rests at zero between reads
  AST_RDATA_IDLE: assert property (!reg_rd
      |=> reg_rdata == 8'h00)
    else $error("read data left standing");
  AST_STRAP_TAKEN: assert property (!captured_ff
      |=> captured_ff && bias_int_ff == $past(bias_internal_opt))
    else $error("bias option not taken after reset");
  AST_STRAP_HELD: assert property (captured_ff |=> $stable(bias_int_ff))
    else $error("bias option changed after capture");
endmodule : opamp_cmp_ctrl

// ### verif/analog_model.sv
// Behavioural amplifiers and comparator behind the control block
`timescale 1ns/1ps
module analog_model #(
  parameter logic [3:0] TRIM_FLIP = 4'h9
) (
  // Control from the block
  input wire logic [2:0] amp_enable,
  input wire logic [11:0] amp_trim,
  input wire logic cmp_enable,
  // Bench stimulus on the comparator inputs
  input wire logic cmp_level,
  // Analog results
  output logic [2:0] amp_out_status,
  output logic comp_out
);
  // Output flips once the trim passes the offset; a disabled amp sits low
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      amp_out_status[i] = amp_enable[i] & (amp_trim[4*i +: 4] >= TRIM_FLIP);
    end
  end
  // A disabled comparator gives a steady low, never a stale level
  assign comp_out = cmp_enable & cmp_level;
endmodule : analog_model

// ### verif/tb_opamp_cmp_ctrl.sv
// Self-checking bench of the amplifier and comparator control block
`timescale 1ns/1ps
`include "opamp_cmp_defs.svh"
module tb_opamp_cmp_ctrl;
  localparam logic [3:0] FLIP = 4'h9;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  opamp_cmp_pkg::addr_t reg_addr = 4'h0;
  opamp_cmp_pkg::byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bias_internal_opt = 1'b1;
  logic cmp_level = 1'b0;
  logic [2:0] pin_ext = 3'h0;
  opamp_cmp_pkg::byte_t reg_rdata;
  logic [2:0] amp_out_status, amp_enable, amp_sw_first, amp_sw_second, amp_sw_short;
  logic [2:0] port_b_in, port_b_out, port_b_oe, port_b_pullup;
  logic [11:0] amp_trim;
  opamp_cmp_pkg::gain_t amp2_gain;
  opamp_cmp_pkg::trim_t cmp_trim;
  logic bias_sw_close, comp_out, cmp_enable, cmp_sw_first, cmp_sw_second, cmp_sw_short, irq;
  logic [3:0] k;
  int error_cnt = 0;
  int n_compared = 0;

  always #5 sys_clk = ~sys_clk;
  // Pin level: driven value, else pull-up, else the outside world
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & (port_b_pullup | pin_ext));

  opamp_cmp_ctrl opamp_cmp_ctrl_i (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bias_internal_opt, .amp_out_status, .amp_enable, .amp_sw_first, .amp_sw_second,
    .amp_sw_short, .amp_trim, .amp2_gain, .bias_sw_close, .comp_out, .cmp_enable,
    .cmp_sw_first, .cmp_sw_second, .cmp_sw_short, .cmp_trim, .port_b_in, .port_b_out,
    .port_b_oe, .port_b_pullup, .irq
  );
  analog_model #(.TRIM_FLIP(FLIP)) analog_model_i (
    .amp_enable, .amp_trim, .cmp_enable, .cmp_level, .amp_out_status, .comp_out
  );

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_out(input string what, input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_out

  task automatic wr(input opamp_cmp_pkg::addr_t a, input opamp_cmp_pkg::byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input opamp_cmp_pkg::addr_t a,
      input opamp_cmp_pkg::byte_t exp);
    opamp_cmp_pkg::byte_t got;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    chk_out(what, 12'(got), 12'(exp));
  endtask : rd_chk

  // Outputs lag a write by two edges and an event by two; four gives margin
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic opt);
    @(posedge sys_clk);
    resetn <= 1'b0;
    bias_internal_opt <= opt;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : do_reset

  // Untouched amps keep both inputs closed and the short open
  function automatic logic [11:0] exp_sw(input int a, input logic rsel, input logic ofm);
    logic [2:0] one;
    one = 3'(1 << a);
    return {one, ~(one & {3{ofm & ~rsel}}), ~(one & {3{ofm & rsel}}), one & {3{ofm}}};
  endfunction : exp_sw

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("BAD watchdog expected finish seen hang");
    give_verdict();
  end

  initial begin
    do_reset(1'b1);
    settle();
    chk_out("reset switches", {amp_enable, amp_sw_first, amp_sw_second, amp_sw_short}, 12'h1F8);
    chk_out("idle bias", bias_sw_close, 1'b0);
    rd_chk("port dir", `PORTB_DIR_OFS, 8'h07);
    rd_chk("unmapped", 4'hF, 8'h00);
    // Index 3 is the comparator, with every amp off
    for (int a = 0; a < 4; a++) begin
      for (int m = 0; m < 4; m++) begin
        wr((a == 3) ? `CMP_CTRL_OFS : 4'(a), {1'b0, 4'(a + m), m[1], m[0], 1'b1});
        settle();
        chk_out("amp decode", {amp_enable, amp_sw_first, amp_sw_second, amp_sw_short},
          exp_sw(a, m[0], m[1]));
        chk_out("cmp decode", {cmp_enable, cmp_sw_first, cmp_sw_second, cmp_sw_short},
          (a == 3) ? {1'b1, ~(m[1] & ~m[0]), ~(m[1] & m[0]), m[1]} : 4'h6);
        chk_out("bias", bias_sw_close, (a < 3) ? 1'b1 : 1'b0);
        chk_out("amp trim", amp_trim, (a < 3) ? 12'(4'(a + m)) << (4 * a) : 12'h000);
        chk_out("cmp trim", cmp_trim, (a == 3) ? 4'(a + m) : 4'h0);
      end
      wr((a == 3) ? `CMP_CTRL_OFS : 4'(a), 8'h00);
    end
    // Calibration: offset mode, reference 0, step the trim until the output flips
    k = 4'h0;
    for (int t = 0; t < 16; t++) begin
      wr(`AMP1_CTRL_OFS, {1'b0, 4'(t), 3'b101});
      settle();
      k = 4'(t);
      if (amp_out_status[0] === 1'b1) break;
    end
    chk_out("trim at flip", amp_trim[3:0], FLIP);
    wr(`AMP1_CTRL_OFS, {1'b0, k, 3'b001});
    settle();
    chk_out("after cal", {amp_enable, amp_sw_first, amp_sw_second, amp_sw_short},
      exp_sw(0, 1'b0, 1'b0));
    chk_out("kept trim", amp_trim[3:0], FLIP);
    wr(`AMP1_CTRL_OFS, 8'h00);
    // Shared pins as plain I/O, then comparator inputs, then comparator output
    wr(`PORTB_DIR_OFS, 8'h02);
    wr(`PORTB_DATA_OFS, 8'h05);
    wr(`PORTB_PULL_OFS, 8'h02);
    wr(`MISC_CTRL_OFS, 8'h05);
    settle();
    chk_out("gpio", {port_b_oe, port_b_out, port_b_pullup}, 9'b101_101_010);
    rd_chk("gpio pins", `PORTB_DATA_OFS, 8'h07);
    chk_out("gain", amp2_gain, 3'h5);
    wr(`CMP_CTRL_OFS, 8'h01);
    settle();
    chk_out("cmp inputs", {port_b_oe, port_b_out, port_b_pullup}, 9'b100_100_000);
    wr(`MISC_CTRL_OFS, 8'h0D);
    wr(`IRQ_MASK_OFS, 8'h01);
    rd_chk("amp events", `IRQ_STAT_OFS, 8'h02);
    cmp_level <= 1'b1;
    settle();
    chk_out("cmp out high", {port_b_oe, port_b_out, port_b_pullup}, 9'b100_100_000);
    chk_out("irq raised", irq, 1'b1);
    rd_chk("cmp pin read", `PORTB_DATA_OFS, 8'h04);
    rd_chk("cmp event", `IRQ_STAT_OFS, 8'h01);
    settle();
    chk_out("irq cleared", irq, 1'b0);
    wr(`IRQ_MASK_OFS, 8'h00);
    cmp_level <= 1'b0;
    settle();
    chk_out("cmp out low", {port_b_oe, port_b_out, port_b_pullup}, 9'b100_000_000);
    chk_out("irq masked", irq, 1'b0);
    rd_chk("masked event", `IRQ_STAT_OFS, 8'h01);
    // External bias option: switches stay open; a late strap change is ignored
    do_reset(1'b0);
    wr(`AMP1_CTRL_OFS, 8'h01);
    bias_internal_opt <= 1'b1;
    settle();
    chk_out("amp1 on", amp_enable, 3'h1);
    chk_out("external bias", bias_sw_close, 1'b0);
    give_verdict();
  end
endmodule : tb_opamp_cmp_ctrl
